// file: design/trxcp_pkg.sv
package trxcp_pkg;

  // Register indexes; byte address on the bus is four times the index
  localparam logic [6:0] IDX_PRIMARY   = 7'h00;
  localparam logic [6:0] IDX_PIN_CFG   = 7'h01;
  localparam logic [6:0] IDX_SUB_CLEAR = 7'h02;
  localparam logic [6:0] IDX_WAKE_SEL  = 7'h03;
  localparam logic [6:0] IDX_TEST_CTL  = 7'h24;
  localparam logic [6:0] IDX_STATUS    = 7'h40;
  localparam logic [6:0] IDX_CLR_DONE  = 7'h41;

  // Reset values
  localparam logic [7:0] PRIMARY_RST   = 8'h01;
  localparam logic [7:0] PIN_CFG_RST   = 8'h00;
  localparam logic [7:0] SUB_CLEAR_RST = 8'h00;
  localparam logic [7:0] WAKE_SEL_RST  = 8'h80;
  localparam logic [7:0] TEST_CTL_RST  = 8'h00;

  // Power-down scheme codes
  localparam logic [1:0] PD_AUTO_RX    = 2'h3;
  localparam logic [1:0] PD_ALL_OFF    = 2'h1;

  // Calibration interval codes and test defaults
  localparam logic [1:0] CAL_NEVER     = 2'h0;
  localparam logic [1:0] CAL_ALWAYS    = 2'h1;
  localparam logic [1:0] CAL_EVERY_16  = 2'h2;
  localparam logic [1:0] CAL_EVERY_256 = 2'h3;
  localparam logic [2:0] TEST_MODE_DEF = 3'h1;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECODE   = 2'h3;

  // Main control register, sequencing layout
  typedef struct packed {
    logic       direction_select;
    logic       freq_set_b;
    logic [1:0] powerdown_scheme;
    logic [1:0] auto_cal_interval;
    logic       sleep_and_arm;
    logic       chip_run_n;
  } trxcp_primary_type;

  // Pin interface configuration register
  typedef struct packed {
    logic osc_skip;
    logic split_data_pins;
    logic clock_gate_on_settle;
    logic clock_gate_on_carrier;
    logic outer_amp_ctrl_on;
    logic outer_rx_amp_ctrl_on;
    logic outer_amp_polarity;
    logic outer_rx_amp_polarity;
  } trxcp_pin_cfg_type;

  // External amplifier and test module controls
  typedef struct packed {
    logic       outer_amp_enable_pin;
    logic       outer_rx_amp_enable_pin;
    logic       test_module_sleep;
    logic [2:0] test_mode;
  } trxcp_pad_type;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF   = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_RUN   = 2'b10,
    SEQ_CAL   = 2'b11
  } trxcp_seq_type;

endpackage

// file: design/trxcp_regs.sv
// What this block does
// - Sequencing runs only while direction select is receive; host keeps it cleared.
// - Power-down scheme three enables sequencing; bits three to one become sequencing controls.
// - Calibration interval: never, every sequence, every 16th, every 256th.
// - Written rising sleep-and-arm bit powers down and arms for next sequence.
// - Chip reset bit low loads defaults except main register; host sets it high.
// - Frequency select bit picks register set A at 0, B at 1.
// - Oscillator skip bit powers down crystal oscillator, takes external rail clock.
// - Split pins off: data pin outputs receive data, inputs transmit data.
// - Split pins on: data pin input; receive data on settled or clock pin.
// - Split on, select wakeup off, scheme three: data pin falling edge starts sequence.
// - Settle gating, scheme 01, synchronous: clock held high unless PLL locked.
// - Carrier gating, synchronous: clock held high unless carrier sense indicated.
// - Outer amp control on: pin asserts with internal PA, else equals polarity.
// - Outer receive amp control on: pin asserts with LNA, else equals polarity.
// - Outer amp polarity sets active level of its enable pin.
// - Outer receive amp polarity sets active level of its enable pin.
// - Any test enable maps low config bits to test sleep and mode, else 1/001.
// - Each submodule clear bit at zero resets one digital block.
// - Submodule clear bits return to one themselves; done status shows completion.
// - Select wakeup on: select pin falling edges start sequencing instead.

module trxcp_regs #(
  parameter int ADDR_W = 9
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,

  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]       avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [3:0]              avs_byteenable_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic      [31:0]             avs_readdata_o,
  output logic      [1:0]              avs_response_o,
  output logic                         avs_waitrequest_o,

  // Radio core status
  input  wire logic                    pll_lock_i,
  input  wire logic                    carrier_sense_i,
  input  wire logic                    sync_mode_i,
  input  wire logic                    rx_data_i,
  input  wire logic                    data_clock_raw_i,
  input  wire logic                    pa_on_i,
  input  wire logic                    lna_on_i,
  input  wire logic                    seq_done_i,
  input  wire logic                    cal_done_i,
  input  wire logic [7:0]              clear_ack_i,

  // Pins
  input  wire logic                    select_pin_i,
  input  wire logic                    data_io_pin_i,
  output logic                         data_io_pin_o,
  output logic                         data_io_pin_oe_o,
  output logic                         settled_pin_o,
  output logic                         data_clock_pin_o,

  // Core controls
  output logic                         tx_data_o,
  output logic                         freq_set_b_o,
  output logic                         osc_skip_o,
  output logic                         chip_sleep_o,
  output logic                         seq_active_o,
  output logic                         cal_start_o,
  output logic [7:0]                   clear_n_o,
  output trxcp_pkg::trxcp_pad_type     pad_o
);
  import trxcp_pkg::*;

  // Whether one register index is mapped; an unmapped one gets a decode error response
  function automatic logic decoded(input logic [6:0] idx);
    return idx == IDX_PRIMARY || idx == IDX_PIN_CFG || idx == IDX_SUB_CLEAR ||
           idx == IDX_WAKE_SEL || idx == IDX_TEST_CTL || idx == IDX_STATUS ||
           idx == IDX_CLR_DONE;
  endfunction

  // Whether this finished sequence ends with a calibration
  function automatic logic cal_due(input logic [1:0] interval, input logic [7:0] cnt);
    case (interval)
      CAL_NEVER:     return 1'b0;
      CAL_ALWAYS:    return 1'b1;
      CAL_EVERY_16:  return cnt[3:0] == 4'hF;
      CAL_EVERY_256: return cnt == 8'hFF;
      default:       return 1'b0;
    endcase
  endfunction

  // Index needs seven bits above the byte lane bits
  if (ADDR_W < 9) begin : g_chk
    $error("ADDR_W must be at least 9");
  end

  // Register state
  trxcp_primary_type primary;
  trxcp_pin_cfg_type pin_cfg;
  logic [7:0]        sub_clear;
  logic              select_pin_wakeup;
  logic              filter_test_on;
  logic              analog_test_on;
  logic [7:0]        clr_done;
  trxcp_seq_type     seq_state;
  logic [7:0]        seq_count;
  logic              select_pin_q;
  logic              data_io_pin_q;

  // Decode and sequencer wires
  logic [6:0]        idx;
  logic              wr_go;
  logic              rd_take;
  logic              chip_clear;
  logic              seq_mode;
  logic              arm_write;
  logic              wake_edge;
  logic              seq_clear;
  trxcp_primary_type wr_primary;
  logic [7:0]        rd_mux;

  // Bus decode; a write lands on the edge where waitrequest is low
  assign idx        = avs_address_i[8:2];
  assign wr_go      = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign rd_take    = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign wr_primary = trxcp_primary_type'(avs_writedata_i[7:0]);
  assign chip_clear = ~primary.chip_run_n;

  // Sequencing only in receive with the automatic scheme
  assign seq_mode = primary.powerdown_scheme == PD_AUTO_RX &&
                    !primary.direction_select;

  // Only a 0 to 1 change of the arm bit counts, not a repeated 1
  assign arm_write = wr_go && idx == IDX_PRIMARY && wr_primary.sleep_and_arm &&
                     !primary.sleep_and_arm &&
                     wr_primary.powerdown_scheme == PD_AUTO_RX &&
                     !wr_primary.direction_select;

  // Wake source: select pin, or data pin when pins are split
  assign wake_edge = select_pin_wakeup ? (select_pin_q & ~select_pin_i)
                   : (pin_cfg.split_data_pins & data_io_pin_q & ~data_io_pin_i);

  assign seq_clear = chip_clear | ~sub_clear[1];

  // Read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      IDX_PRIMARY:   rd_mux = primary;
      IDX_PIN_CFG:   rd_mux = pin_cfg;
      IDX_SUB_CLEAR: rd_mux = sub_clear;
      IDX_WAKE_SEL:  rd_mux = {select_pin_wakeup, 7'h00};
      IDX_TEST_CTL:  rd_mux = {6'h00, filter_test_on, analog_test_on};
      IDX_STATUS:    rd_mux = {pll_lock_i, carrier_sense_i, 3'h0, chip_sleep_o, seq_state};
      IDX_CLR_DONE:  rd_mux = clr_done;
      default:       rd_mux = 8'h00;
    endcase
  end

  // Bus handshake: one wait cycle, then a single low waitrequest cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      avs_response_o    <= RESP_OKAY;
    end else begin
      // One low cycle, so a held request is not taken twice
      avs_waitrequest_o <= ~rd_take;
      if (rd_take) begin
        avs_readdata_o <= {24'h00_0000, rd_mux};
        avs_response_o <= decoded(idx) ? RESP_OKAY : RESP_DECODE;
      end
    end
  end

  // Main register has no soft default; it is only ever written directly
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      primary <= trxcp_primary_type'(PRIMARY_RST);
    end else if (wr_go && idx == IDX_PRIMARY) begin
      primary <= wr_primary;
    end
  end

  // Pin config, wake select and test enables fall back to defaults in chip reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || chip_clear) begin
      pin_cfg           <= trxcp_pin_cfg_type'(PIN_CFG_RST);
      select_pin_wakeup <= WAKE_SEL_RST[7];
      filter_test_on    <= TEST_CTL_RST[1];
      analog_test_on    <= TEST_CTL_RST[0];
    end else if (wr_go) begin
      if (idx == IDX_PIN_CFG) begin
        pin_cfg <= trxcp_pin_cfg_type'(avs_writedata_i[7:0]);
      end

      if (idx == IDX_WAKE_SEL) begin
        select_pin_wakeup <= avs_writedata_i[7];
      end

      if (idx == IDX_TEST_CTL) begin
        filter_test_on <= avs_writedata_i[1];
        analog_test_on <= avs_writedata_i[0];
      end
    end
  end

  // Clear bits self-set the cycle after they fire, so a write of 0 is a pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || chip_clear) begin
      sub_clear <= SUB_CLEAR_RST;
    end else if (wr_go && idx == IDX_SUB_CLEAR) begin
      sub_clear <= avs_writedata_i[7:0];
    end else begin
      sub_clear <= 8'hFF;
    end
  end

  // Done bits drop when a block is cleared and rise on its acknowledge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      clr_done <= 8'h00;
    end else begin
      clr_done <= (clr_done | clear_ack_i) & clear_n_o;
    end
  end

  // Block clear outputs; chip reset clears every block
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      clear_n_o <= 8'h00;
    end else begin
      clear_n_o <= sub_clear & {8{~chip_clear}};
    end
  end

  // Pin history for falling edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      select_pin_q  <= 1'b1;
      data_io_pin_q <= 1'b1;
    end else begin
      select_pin_q  <= select_pin_i;
      data_io_pin_q <= data_io_pin_i;
    end
  end

  // Power-up sequencer; the radio timers report the end of a sequence
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || seq_clear) begin
      seq_state <= SEQ_OFF;
      seq_count <= 8'h00;
    end else if (!seq_mode && !arm_write) begin
      seq_state <= SEQ_OFF;
    end else begin
      case (seq_state)
        SEQ_OFF: begin
          if (arm_write) begin
            seq_state <= SEQ_ARMED;
          end
        end

        SEQ_ARMED: begin
          if (wake_edge) begin
            seq_state <= SEQ_RUN;
          end
        end

        SEQ_RUN: begin
          // Re-arming aborts a running sequence
          if (arm_write) begin
            seq_state <= SEQ_ARMED;
          end else if (seq_done_i) begin
            seq_count <= seq_count + 8'h01;
            seq_state <= cal_due(primary.auto_cal_interval, seq_count) ? SEQ_CAL
                                                                       : SEQ_ARMED;
          end
        end

        SEQ_CAL: begin
          // Core reports the end of calibration
          if (cal_done_i) begin
            seq_state <= SEQ_ARMED;
          end
        end

        default: seq_state <= SEQ_OFF;
      endcase
    end
  end

  // Sequencer outputs; calibration start is a one-cycle pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      chip_sleep_o <= 1'b0;
      seq_active_o <= 1'b0;
      cal_start_o  <= 1'b0;
    end else begin
      chip_sleep_o <= seq_state == SEQ_ARMED;
      seq_active_o <= seq_state == SEQ_RUN || seq_state == SEQ_CAL;
      cal_start_o  <= seq_state == SEQ_RUN && seq_mode && !seq_clear && !arm_write &&
                      seq_done_i && cal_due(primary.auto_cal_interval, seq_count);
    end
  end

  // Core controls taken straight from register fields
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      freq_set_b_o <= 1'b0;
      osc_skip_o   <= 1'b0;
    end else begin
      freq_set_b_o <= primary.freq_set_b;
      osc_skip_o   <= pin_cfg.osc_skip;
    end
  end

  // Data pin direction and receive data routing
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      data_io_pin_o    <= 1'b0;
      data_io_pin_oe_o <= 1'b0;
      tx_data_o        <= 1'b0;
      settled_pin_o    <= 1'b0;
    end else begin
      data_io_pin_o    <= rx_data_i;

      // Split pins make the data pin a pure input
      data_io_pin_oe_o <= ~pin_cfg.split_data_pins & ~primary.direction_select;
      tx_data_o        <= data_io_pin_i;
      settled_pin_o    <= (pin_cfg.split_data_pins & sync_mode_i) ? rx_data_i
                                                                  : pll_lock_i;
    end
  end

  // Data clock pin; gating forces it high, never low
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      data_clock_pin_o <= 1'b1;
    end else if (pin_cfg.split_data_pins && !sync_mode_i) begin
      data_clock_pin_o <= rx_data_i;
    end else if (sync_mode_i && pin_cfg.clock_gate_on_settle &&
                 primary.powerdown_scheme == PD_ALL_OFF && !pll_lock_i) begin
      data_clock_pin_o <= 1'b1;
    end else if (sync_mode_i && pin_cfg.clock_gate_on_carrier && !carrier_sense_i) begin
      // Host must keep this gating off in transmit
      data_clock_pin_o <= 1'b1;
    end else begin
      data_clock_pin_o <= data_clock_raw_i;
    end
  end

  // External amplifier enables and analog test module controls
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pad_o <= '{1'b0, 1'b0, 1'b1, TEST_MODE_DEF};
    end else begin
      // Active level equals the polarity bit, idle level its inverse
      pad_o.outer_amp_enable_pin <= (pin_cfg.outer_amp_ctrl_on & ~pa_on_i) ^
                                    pin_cfg.outer_amp_polarity;
      pad_o.outer_rx_amp_enable_pin <= (pin_cfg.outer_rx_amp_ctrl_on & ~lna_on_i) ^
                                       pin_cfg.outer_rx_amp_polarity;

      if (filter_test_on || analog_test_on) begin
        pad_o.test_module_sleep <= pin_cfg.outer_amp_ctrl_on;
        pad_o.test_mode         <= {pin_cfg.outer_rx_amp_ctrl_on, pin_cfg.outer_amp_polarity,
                                    pin_cfg.outer_rx_amp_polarity};
      end else begin
        pad_o.test_module_sleep <= 1'b1;
        pad_o.test_mode         <= TEST_MODE_DEF;
      end
    end
  end

endmodule // trxcp_regs

// file: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import trxcp_pkg::*;

  logic clk, rst_b, lock, cs, sync, rxd, raw, pa, lna, sdone, cdone, sel, data_io_pin, dio_w;
  logic dio_o, dio_oe, settled, data_clock_pin, txd, fsb, oskip, sleep, active, cal, rd, wr, wt;
  logic [7:0]    ack, clr_n;
  logic [8:0]    adr;
  logic [3:0]    be;
  logic [31:0]   wd, rdat, q;
  logic [1:0]    resp, r;
  trxcp_pad_type pad;
  int            n_errors, compares, cycles, cal_cnt;

  // Shared data pin: the block wins while it drives
  assign dio_w = dio_oe ? dio_o : data_io_pin;

  trxcp_regs trxcp_regs_i (
    .clk_sys_i(clk), .rst_b_i(rst_b), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_response_o(resp), .avs_waitrequest_o(wt), .pll_lock_i(lock),
    .carrier_sense_i(cs), .sync_mode_i(sync), .rx_data_i(rxd), .data_clock_raw_i(raw),
    .pa_on_i(pa), .lna_on_i(lna), .seq_done_i(sdone), .cal_done_i(cdone),
    .clear_ack_i(ack), .select_pin_i(sel), .data_io_pin_i(dio_w), .data_io_pin_o(dio_o),
    .data_io_pin_oe_o(dio_oe), .settled_pin_o(settled), .data_clock_pin_o(data_clock_pin),
    .tx_data_o(txd), .freq_set_b_o(fsb), .osc_skip_o(oskip), .chip_sleep_o(sleep),
    .seq_active_o(active), .cal_start_o(cal), .clear_n_o(clr_n), .pad_o(pad)
  );

  trxcp_host trxcp_host_i (
    .clk_sys_i(clk), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
    .avs_byteenable_o(be), .avs_writedata_o(wd), .avs_readdata_i(rdat),
    .avs_response_i(resp), .avs_waitrequest_i(wt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard and calibration pulse counter
  always @(posedge clk) begin
    cycles++;
    if (cal) cal_cnt++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
    trxcp_host_i.rd(idx, q, r);
    chk({r, q[29:0]}, {RESP_OKAY, 22'h0, exp});
  endtask

  // Long enough for any registered output to follow its cause
  task automatic nap;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic t_regs;
    rdchk(IDX_PRIMARY, 8'h01);
    rdchk(IDX_PIN_CFG, 8'h00);
    rdchk(IDX_SUB_CLEAR, 8'hFF);
    rdchk(IDX_CLR_DONE, 8'h00);
    @(posedge clk);
    ack <= 8'hFF;
    @(posedge clk);
    ack <= 8'h00;
    rdchk(IDX_CLR_DONE, 8'hFF);
    trxcp_host_i.rd(7'h10, q, r);
    chk({r, q[29:0]}, {RESP_DECODE, 30'h0});
  endtask

  task automatic t_pins;
    for (int v = 0; v < 64; v++) begin
      trxcp_host_i.wr(IDX_TEST_CTL, {6'h0, v[4] & v[5], v[4] & !v[5]});
      trxcp_host_i.wr(IDX_PIN_CFG, {4'h0, v[3:0]});
      @(posedge clk);
      pa  <= v[5];
      lna <= !v[5];
      nap();
      chk({26'h0, pad}, {26'h0, v[1] ^ (v[3] & v[5]) ^ v[3], v[0] ^ (v[2] & v[5]),
          v[4] ? v[3:0] : 4'h9});
    end
  endtask

  task automatic t_data;
    for (int s = 0; s < 8; s++) begin
      trxcp_host_i.wr(IDX_PIN_CFG, {s[0], s[1], 6'h0});
      @(posedge clk);
      sync <= s[2];
      rxd  <= s[0];
      raw  <= !s[0];
      lock <= !s[0];
      data_io_pin  <= !s[0];
      nap();
      chk({oskip, dio_oe, dio_oe & dio_o, txd, settled, data_clock_pin}, {s[0], !s[1], !s[1] & s[0],
          s[1] ^ s[0], (s[1] & s[2]) ^ !s[0], (s[1] & !s[2]) ^ !s[0]});
    end
  endtask

  task automatic t_gate;
    // Carrier gating only with direction at receive
    logic [19:0] t [7] = '{20'h51203, 20'h5120A, 20'h01202, 20'h01103, 20'h01106,
                           20'h01002, 20'h01100};
    for (int i = 0; i < 7; i++) begin
      trxcp_host_i.wr(IDX_PRIMARY, t[i][19:12]);
      trxcp_host_i.wr(IDX_PIN_CFG, t[i][11:4]);
      @(posedge clk);
      lock <= t[i][3];
      cs   <= t[i][2];
      sync <= t[i][1];
      raw  <= 1'b0;
      nap();
      chk({data_clock_pin, fsb}, {t[i][0], t[i][18]});
    end
  endtask

  task automatic t_seq;
    int exp [4] = '{0, 16, 1, 0};
    for (int c = 0; c < 4; c++) begin
      trxcp_host_i.wr(IDX_SUB_CLEAR, 8'hFD);
      trxcp_host_i.arm(c[1:0]);
      cal_cnt = 0;
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        sel <= 1'b0;
        nap();
        chk({sleep, active}, 2'h1);
        @(posedge clk);
        sel   <= 1'b1;
        sdone <= 1'b1;
        @(posedge clk);
        sdone <= 1'b0;
        nap();
        @(posedge clk);
        cdone <= 1'b1;
        @(posedge clk);
        cdone <= 1'b0;
        nap();
        chk(sleep, 1'b1);
      end
      chk(cal_cnt, exp[c]);
    end
    trxcp_host_i.wr(IDX_PRIMARY, 8'hB1);
    trxcp_host_i.wr(IDX_PRIMARY, 8'hB3);
    nap();
    chk(sleep, 1'b0);
    trxcp_host_i.wr(IDX_PIN_CFG, 8'h40);
    trxcp_host_i.wr(IDX_WAKE_SEL, 8'h00);
    trxcp_host_i.arm(CAL_NEVER);
    @(posedge clk);
    sel <= 1'b0;
    data_io_pin <= 1'b1;
    nap();
    chk({sleep, active}, 2'h2);
    @(posedge clk);
    data_io_pin <= 1'b0;
    nap();
    chk({sleep, active}, 2'h1);
    rdchk(IDX_STATUS, 8'h02);
  endtask

  task automatic t_clear;
    trxcp_host_i.wr(IDX_PRIMARY, 8'h01);
    trxcp_host_i.wr(IDX_SUB_CLEAR, 8'hA5);
    @(posedge clk);
    @(negedge clk);
    chk(clr_n, 8'hA5);
    @(negedge clk);
    chk(clr_n, 8'hFF);
    rdchk(IDX_CLR_DONE, 8'hA5);
    trxcp_host_i.wr(IDX_PIN_CFG, 8'h0F);
    trxcp_host_i.wr(IDX_PRIMARY, 8'h00);
    nap();
    chk(clr_n, 8'h00);
    trxcp_host_i.wr(IDX_PIN_CFG, 8'h0C);
    trxcp_host_i.wr(IDX_PRIMARY, 8'h01);
    rdchk(IDX_PIN_CFG, 8'h00);
    rdchk(IDX_PRIMARY, 8'h01);
  endtask

  // Inputs idle at time zero, reset held for eight cycles
  initial begin
    {rst_b, lock, cs, sync, rxd, raw, pa, lna, sdone, cdone, ack} = '0;
    {sel, data_io_pin} = 2'h3;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_data();
    t_gate();
    t_seq();
    t_clear();
    results();
  end
endmodule // testbench

// file: dv/trxcp_host.sv
module trxcp_host (
  // Clock
  input  wire logic        clk_sys_i,
  // Avalon-MM master
  output logic [8:0]       avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic [3:0]       avs_byteenable_o,
  output logic [31:0]      avs_writedata_o,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic [1:0]  avs_response_i,
  input  wire logic        avs_waitrequest_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    avs_address_o    = 9'h1FF;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_byteenable_o = 4'hF;
    avs_writedata_o  = 32'h0;
  end

  // One transfer; address and data are scrambled once released
  task automatic access(input logic rd, input logic [6:0] idx, input logic [7:0] d,
                        output logic [31:0] q, output logic [1:0] r);
    @(posedge clk_sys_i);
    avs_address_o   <= {idx, 2'h0};
    avs_read_o      <= rd;
    avs_write_o     <= !rd;
    avs_writedata_o <= {24'h0, d};
    @(posedge clk_sys_i);
    while (avs_waitrequest_i) @(posedge clk_sys_i);
    q = avs_readdata_i;
    r = avs_response_i;
    avs_read_o      <= 1'b0;
    avs_write_o     <= 1'b0;
    avs_address_o   <= ~avs_address_o;
    avs_writedata_o <= ~avs_writedata_o;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    access(1'b0, idx, d, q, r);
  endtask

  task automatic rd(input logic [6:0] idx, output logic [31:0] q, output logic [1:0] r);
    access(1'b1, idx, 8'h0, q, r);
  endtask

  // Sequencing is only armed with direction at receive
  task automatic arm(input logic [1:0] c);
    wr(7'h00, {4'h3, c, 2'h1});
    wr(7'h00, {4'h3, c, 2'h3});
  endtask
endmodule // trxcp_host

// file: dv/trxcp_regs_assertions.sv
module trxcp_regs_assertions #(
  parameter int ADDR_W = 9
) (
  // Clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     rst_b_i,
  // Register bus
  input wire logic [ADDR_W-1:0]        avs_address_i,
  input wire logic                     avs_read_i,
  input wire logic                     avs_write_i,
  input wire logic [3:0]               avs_byteenable_i,
  input wire logic [31:0]              avs_writedata_i,
  input wire logic [31:0]              avs_readdata_o,
  input wire logic [1:0]               avs_response_o,
  input wire logic                     avs_waitrequest_o,
  // Core status and pins
  input wire logic                     pll_lock_i,
  input wire logic                     sync_mode_i,
  input wire logic                     rx_data_i,
  input wire logic                     pa_on_i,
  input wire logic                     data_io_pin_oe_o,
  input wire logic                     settled_pin_o,
  input wire logic                     chip_sleep_o,
  input wire logic                     cal_start_o,
  input wire logic [7:0]               clear_n_o,
  input wire trxcp_pkg::trxcp_pad_type pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import trxcp_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [7:0] pm;
  logic [7:0] cfg;
  logic       ok;
  logic [6:0] idx;
  logic       take;
  logic       mapped;

  // Decode of the request in flight
  assign idx    = avs_address_i[8:2];
  assign take   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign mapped = idx inside {IDX_PRIMARY, IDX_PIN_CFG, IDX_SUB_CLEAR, IDX_WAKE_SEL,
                              IDX_TEST_CTL, IDX_STATUS, IDX_CLR_DONE};

  // Mirrors; ok skips the cycles around a chip reset, where the lag is loose
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pm  <= PRIMARY_RST;
      cfg <= PIN_CFG_RST;
      ok  <= 1'b0;
    end else begin
      ok <= pm[0];
      if (take && idx == IDX_PRIMARY) pm <= avs_writedata_i[7:0];
      if (!pm[0]) cfg <= PIN_CFG_RST;
      else if (take && idx == IDX_PIN_CFG) cfg <= avs_writedata_i[7:0];
    end
  end

  wait_one_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered on next edge");
  bad_index_a: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_response_o == (mapped ? RESP_OKAY : RESP_DECODE))
    else $error("wrong response code");
  cfg_read_a: assert property (
    avs_read_i && !avs_waitrequest_o && idx == IDX_PIN_CFG |-> avs_readdata_o == {24'h0, cfg})
    else $error("pin config readback wrong");
  dio_dir_a: assert property (
    ok && pm[0] |-> data_io_pin_oe_o == $past(!cfg[6] && !pm[7]))
    else $error("data pin direction wrong");
  settle_pin_a: assert property (
    ok && pm[0] |-> settled_pin_o == $past(cfg[6] && sync_mode_i ? rx_data_i : pll_lock_i))
    else $error("settled pin wrong");
  amp_pin_a: assert property (
    ok && pm[0] |-> pad_o.outer_amp_enable_pin == $past((cfg[3] && !pa_on_i) ^ cfg[1]))
    else $error("amplifier enable pin wrong");
  arm_sleep_a: assert property (
    take && idx == IDX_PRIMARY && pm[0] && !pm[1] && !avs_writedata_i[7]
    && avs_writedata_i[5:4] == PD_AUTO_RX && avs_writedata_i[1:0] == 2'h3 |-> ##2 chip_sleep_o)
    else $error("arming did not sleep");
  clear_pulse_a: assert property (
    take && idx == IDX_SUB_CLEAR && pm[0]
    |-> ##2 clear_n_o == $past(avs_writedata_i[7:0], 2) ##1 clear_n_o == 8'hFF)
    else $error("block clear pulse wrong");
  cal_single_a: assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration start longer than one cycle");

  cover property (chip_sleep_o);
  cover property (cal_start_o);
  cover property (clear_n_o == 8'hA5);
endmodule // trxcp_regs_assertions

bind trxcp_regs trxcp_regs_assertions #(.ADDR_W(ADDR_W)) trxcp_regs_assertions_i (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pll_lock_i(pll_lock_i), .sync_mode_i(sync_mode_i), .rx_data_i(rx_data_i),
  .pa_on_i(pa_on_i), .data_io_pin_oe_o(data_io_pin_oe_o), .settled_pin_o(settled_pin_o),
  .chip_sleep_o(chip_sleep_o), .cal_start_o(cal_start_o), .clear_n_o(clear_n_o),
  .pad_o(pad_o)
);
